// >>> logic/gcn_pkg.sv
// gcn_pkg: constants shared by the global clock net and loop controller
// assumes a 100 MHz system clock and an APB register port with 8-bit addresses
package gcn_pkg;
    // clock and timing
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCK_TIME_US = 50;
    localparam int LOCK_CYC = LOCK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int REF_TIMEOUT_US = 200;
    localparam int REF_TIMEOUT_CYC = REF_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int LF_FREQ_HZ = 10000;
    localparam int LF_HALF_CYC = CLK_MHZ * 1000000 / (2 * LF_FREQ_HZ);
    localparam int HF_FREQ_KHZ = 48000;
    localparam int HF_HALF_RAW = CLK_MHZ * 1000 / (2 * HF_FREQ_KHZ);
    localparam int HF_HALF_CYC = (HF_HALF_RAW < 1) ? 1 : HF_HALF_RAW;
    // structure
    localparam int NUM_GLOBAL_BUFFER = 8;
    localparam int NUM_LUT_IN = 4;
    localparam int LF_BUF = 4;
    localparam int HF_BUF = 5;
    localparam logic [7:0] PIN_MASK = 8'hcf;
    localparam int SHIFT_W = 16;
    localparam int SYNC_W = 14;
    // loop reset and configuration busy reset high, so pins stay high-z until busy is seen low
    localparam logic [13:0] SYNC_RST = 14'h2400;
    localparam logic [2:0] MAX_DIV_LOG2 = 3'h6;
    // register offsets
    localparam logic [7:0] ADDR_ROUTE = 8'h00;
    localparam logic [7:0] ADDR_LOOP = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // routing register fields
    localparam int ROUTE_W = 21;
    localparam int ROUTE_CLK_LSB = 0;
    localparam int ROUTE_LUT_LSB = 3;
    localparam int ROUTE_SR_LSB = 15;
    localparam int ROUTE_CE_LSB = 17;
    localparam int ROUTE_SR_USED = 19;
    localparam int ROUTE_SR_ASYNC = 20;
    localparam logic [20:0] ROUTE_RST = 21'h000000;
    // loop register fields
    localparam int LOOP_DIV_LSB = 0;
    localparam int LOOP_BYPASS = 3;
    localparam int LOOP_HOLD = 4;
    localparam int LOOP_DYN = 5;
    localparam int LOOP_REF_LSB = 6;
    localparam int LOOP_FB = 8;
    localparam int LOOP_PHASE_LSB = 12;
    localparam logic [15:0] LOOP_RST = 16'h0000;
    // status register fields
    localparam int STAT_LOCK = 8;
    localparam int STAT_BUSY = 9;
    localparam int STAT_LRST = 10;
    // reference source codes
    localparam logic [1:0] REF_PIN = 2'h0;
    localparam logic [1:0] REF_HF = 2'h1;
    localparam logic [1:0] REF_LF = 2'h2;
    // lock tracking states
    typedef enum logic [1:0] {
        LS_RESET = 2'b00,
        LS_ACQ = 2'b01,
        LS_LOCK = 2'b10
    } gcn_lock_t;
endpackage

// >>> logic/gcn_clock_ctrl.sv
// gcn_clock_ctrl: global buffers, block control routing, configuration
// tristate/reset and the frequency loop model with serial reprogramming
// assumes pins and the serial port arrive asynchronously; fabric inputs share i_clk
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module gcn_clock_ctrl #(
    parameter int LOCK_CYC = gcn_pkg::LOCK_CYC,
    parameter int REF_TIMEOUT = gcn_pkg::REF_TIMEOUT_CYC,
    parameter int LF_HALF = gcn_pkg::LF_HALF_CYC,
    parameter int HF_HALF = gcn_pkg::HF_HALF_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [gcn_pkg::NUM_GLOBAL_BUFFER-1:0] i_global_pin,
    input wire logic i_config_busy,
    input wire logic i_loop_ref_pin,
    input wire logic i_loop_ref_fabric,
    input wire logic i_loop_feedback_pin,
    input wire logic i_loop_feedback_in,
    input wire logic i_loop_sclk,
    input wire logic i_loop_serial_data_in,
    input wire logic i_loop_reset_n,
    input wire logic [7:0] i_fine_delay_ctrl,
    output logic [gcn_pkg::NUM_GLOBAL_BUFFER-1:0] o_global_buffer,
    output logic [gcn_pkg::NUM_GLOBAL_BUFFER-1:0] o_pin_gpio,
    output logic o_global_tristate_ctrl,
    output logic o_global_reset,
    output logic o_blk_clk,
    output logic [gcn_pkg::NUM_LUT_IN-1:0] o_blk_lut_in,
    output logic o_blk_set_reset,
    output logic o_blk_clk_en,
    output logic o_blk_sr_async,
    output logic o_loop_out_to_global,
    output logic o_loop_out_to_fabric,
    output logic o_loop_lock,
    output logic [7:0] o_fine_delay
);
    import gcn_pkg::*;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // buffer select decode, shared by every block input
    function automatic logic pick(input logic [7:0] b, input logic [2:0] s);
        return b[s];
    endfunction

    // two-flop synchroniser; stage one feeds only stage two
    logic [SYNC_W-1:0] sync1, sync2;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
        end else if (i_ce) begin
            sync1 <= {i_loop_reset_n, i_loop_serial_data_in, i_loop_sclk, i_config_busy,
                i_loop_feedback_pin, i_loop_ref_pin, i_global_pin};
            sync2 <= sync1;
        end
    end
    wire [7:0] pin_s = sync2[7:0];
    wire busy_s = sync2[10];
    wire sclk_s = sync2[11];
    wire sdi_s = sync2[12];
    wire loop_rst_n = sync2[13];

    // on-chip oscillators as toggle dividers of i_clk
    localparam int OSC_HALF [2] = '{LF_HALF, HF_HALF};
    logic [1:0] osc_clk;
    for (genvar g = 0; g < 2; g++) begin : g_osc
        logic [15:0] cnt, next_cnt;
        logic tgl, next_tgl;
        always_comb begin
            next_cnt = cnt + 16'h0001;
            next_tgl = tgl;
            if (cnt == 16'(OSC_HALF[g] - 1)) begin
                next_cnt = 16'h0000;
                next_tgl = ~tgl;
            end
        end
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                cnt <= 16'h0000;
                tgl <= 1'b0;
            end else if (i_ce) begin
                cnt <= next_cnt;
                tgl <= next_tgl;
            end
        end
        assign osc_clk[g] = tgl;
    end

    // global buffer sources
    // eight global buffers
    for (genvar g = 0; g < NUM_GLOBAL_BUFFER; g++) begin : g_global_buffer
        if (g == LF_BUF) begin : g_lf
            assign o_global_buffer[g] = osc_clk[0];
        end else if (g == HF_BUF) begin : g_hf
            assign o_global_buffer[g] = osc_clk[1];
        end else begin : g_pin
            assign o_global_buffer[g] = pin_s[g];
        end
    end
    assign o_pin_gpio = pin_s & PIN_MASK;

    // configuration: tristate while busy, clear held one cycle past the end
    logic busy_d, cfg_clear;
    assign cfg_clear = busy_s | busy_d;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            busy_d <= 1'b1;
            o_global_tristate_ctrl <= 1'b1;
            o_global_reset <= 1'b1;
        end else if (i_ce) begin
            busy_d <= busy_s;
            o_global_tristate_ctrl <= busy_s;
            o_global_reset <= cfg_clear;
        end
    end

    // register file, serial shifter and apb read path
    logic [ROUTE_W-1:0] route_r, next_route;
    logic [15:0] loop_r, next_loop, shreg, next_shreg;
    logic [31:0] next_prdata;
    logic next_slverr, sclk_d, rstn_d, rd_held, next_rd_held;
    wire sclk_rise = sclk_s & ~sclk_d;
    wire rst_rise = loop_rst_n & ~rstn_d;
    wire capture = i_psel & ~rd_held;
    wire wr = i_psel & i_penable & i_pwrite & o_pready;
    always_comb begin
        next_route = route_r;
        next_loop = loop_r;
        next_shreg = shreg;
        next_prdata = o_prdata;
        next_slverr = o_pslverr;
        next_rd_held = rd_held;
        if (wr && i_paddr == ADDR_ROUTE) begin
            next_route = i_pwdata[ROUTE_W-1:0];
        end
        if (wr && i_paddr == ADDR_LOOP) begin
            next_loop = i_pwdata[15:0];
        end
        if (sclk_rise) begin
            next_shreg = {shreg[SHIFT_W-2:0], sdi_s};
        end
        // reset release loads settings; beats a bus write
        if (rst_rise) begin
            next_loop = shreg;
        end
        // read data is taken once per transfer, normally in the setup cycle;
        // a setup cycle lost to a low clock enable costs one wait state
        if (capture) begin
            next_rd_held = 1'b1;
            next_slverr = 1'b0;
            next_prdata = 32'h00000000;
            case (i_paddr)
                ADDR_ROUTE: next_prdata[ROUTE_W-1:0] = route_r;
                ADDR_LOOP: next_prdata[15:0] = loop_r;
                ADDR_STATUS: begin
                    next_prdata[7:0] = o_global_buffer;
                    next_prdata[STAT_LOCK] = o_loop_lock;
                    next_prdata[STAT_BUSY] = busy_s;
                    next_prdata[STAT_LRST] = ~loop_rst_n;
                end
                default: next_slverr = 1'b1;
            endcase
        end
        // the completing edge frees the holder for the next transfer
        if (i_psel && i_penable && o_pready) begin
            next_rd_held = 1'b0;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            route_r <= ROUTE_RST;
            loop_r <= LOOP_RST;
            shreg <= 16'h0000;
            sclk_d <= 1'b0;
            rstn_d <= 1'b1;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
            rd_held <= 1'b0;
        end else if (i_ce) begin
            route_r <= next_route;
            loop_r <= next_loop;
            shreg <= next_shreg;
            sclk_d <= sclk_s;
            rstn_d <= loop_rst_n;
            o_prdata <= next_prdata;
            o_pslverr <= next_slverr;
            rd_held <= next_rd_held;
        end
    end
    // a frozen block cannot take a transfer, nor one whose read data is not yet held
    assign o_pready = i_ce & rd_held;

    // logic block control selection, one set shared by all eight cells
    logic next_blk_clk, next_sr, next_ce, sr_src;
    logic [NUM_LUT_IN-1:0] next_lut;
    assign sr_src = pick(o_global_buffer, {route_r[ROUTE_SR_LSB +: 2], 1'b0});
    always_comb begin
        next_blk_clk = pick(o_global_buffer, route_r[ROUTE_CLK_LSB +: 3]);
        for (int i = 0; i < NUM_LUT_IN; i++) begin
            next_lut[i] = pick(o_global_buffer, route_r[ROUTE_LUT_LSB + 3 * i +: 3]);
        end
        next_ce = pick(o_global_buffer, {route_r[ROUTE_CE_LSB +: 2], 1'b1});
        next_sr = 1'b0;
        if (cfg_clear) begin
            next_sr = 1'b1;
        end else if (route_r[ROUTE_SR_USED]) begin
            next_sr = sr_src;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_blk_clk <= 1'b0;
            o_blk_lut_in <= '0;
            o_blk_set_reset <= 1'b1;
            o_blk_clk_en <= 1'b0;
            o_blk_sr_async <= 1'b0;
        end else if (i_ce) begin
            o_blk_clk <= next_blk_clk;
            o_blk_lut_in <= next_lut;
            o_blk_set_reset <= next_sr;
            o_blk_clk_en <= next_ce;
            o_blk_sr_async <= route_r[ROUTE_SR_ASYNC];
        end
    end

    // loop: source muxes, activity watchdogs, lock tracking, output divider
    gcn_lock_t st, next_st;
    logic [31:0] lock_cnt, next_lock_cnt;
    logic [15:0] ref_wd, fb_wd, next_ref_wd, next_fb_wd;
    logic [6:0] div_cnt;
    logic ref_d, fb_d, ref_now, fb_now, next_out, next_lock, syn_clk;
    logic [2:0] div_raw, div_log2;
    logic [6:0] phased;
    logic act, phase_chg, dyn;
    always_comb begin
        case (loop_r[LOOP_REF_LSB +: 2])
            REF_PIN: ref_now = sync2[8];
            REF_HF: ref_now = osc_clk[1];
            REF_LF: ref_now = osc_clk[0];
            default: ref_now = i_loop_ref_fabric;
        endcase
        fb_now = loop_r[LOOP_FB] ? sync2[9] : i_loop_feedback_in;
    end
    assign div_raw = loop_r[LOOP_DIV_LSB +: 3];
    assign div_log2 = (div_raw > MAX_DIV_LOG2) ? MAX_DIV_LOG2 : div_raw;
    assign phased = div_cnt + {3'h0, loop_r[LOOP_PHASE_LSB +: 4]};
    assign syn_clk = phased[div_log2];
    assign dyn = loop_r[LOOP_DYN];
    assign act = (ref_wd < 16'(REF_TIMEOUT)) && (fb_wd < 16'(REF_TIMEOUT));
    assign phase_chg = dyn && (next_loop[LOOP_PHASE_LSB +: 4] != loop_r[LOOP_PHASE_LSB +: 4]);
    always_comb begin
        next_ref_wd = (ref_wd == 16'hffff) ? ref_wd : ref_wd + 16'h0001;
        next_fb_wd = (fb_wd == 16'hffff) ? fb_wd : fb_wd + 16'h0001;
        if (ref_now && !ref_d) begin
            next_ref_wd = 16'h0000;
        end
        if (fb_now && !fb_d) begin
            next_fb_wd = 16'h0000;
        end
        next_st = st;
        next_lock_cnt = lock_cnt;
        case (st)
            LS_RESET: begin
                next_st = LS_ACQ;
                next_lock_cnt = 32'h00000000;
            end
            LS_ACQ: begin
                if (!act) begin
                    next_lock_cnt = 32'h00000000;
                end else if (lock_cnt == 32'(LOCK_CYC - 1)) begin
                    next_st = LS_LOCK;
                end else begin
                    next_lock_cnt = lock_cnt + 32'h00000001;
                end
            end
            LS_LOCK: begin
                if (!act) begin
                    next_st = LS_ACQ;
                    next_lock_cnt = 32'h00000000;
                end
            end
            default: next_st = LS_RESET;
        endcase
        if (phase_chg && st != LS_RESET) begin
            next_st = LS_ACQ;
            next_lock_cnt = 32'h00000000;
        end
        if (!loop_rst_n || cfg_clear) begin
            next_st = LS_RESET;
        end
        next_lock = (next_st == LS_LOCK);
        next_out = o_loop_out_to_global;
        if (!loop_r[LOOP_HOLD]) begin
            next_out = loop_r[LOOP_BYPASS] ? ref_now : syn_clk;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= LS_RESET;
            lock_cnt <= 32'h00000000;
            ref_wd <= 16'hffff;
            fb_wd <= 16'hffff;
            ref_d <= 1'b0;
            fb_d <= 1'b0;
            div_cnt <= 7'h00;
            o_loop_lock <= 1'b0;
            o_loop_out_to_global <= 1'b0;
            o_fine_delay <= 8'h00;
        end else if (i_ce) begin
            st <= next_st;
            lock_cnt <= next_lock_cnt;
            ref_wd <= next_ref_wd;
            fb_wd <= next_fb_wd;
            ref_d <= ref_now;
            fb_d <= fb_now;
            div_cnt <= div_cnt + 7'h01;
            o_loop_lock <= next_lock;
            o_loop_out_to_global <= next_out;
            o_fine_delay <= dyn ? i_fine_delay_ctrl : 8'h00;
        end
    end
    assign o_loop_out_to_fabric = o_loop_out_to_global;

    // checks on configuration, block control and loop behaviour
    sequence s_release;
        i_ce && rst_rise;
    endsequence
    sequence s_relock;
        i_ce && phase_chg && st != LS_RESET && loop_rst_n && !cfg_clear;
    endsequence
    property p_tristate;
        i_ce && busy_s |=> o_global_tristate_ctrl;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("pins left driven during configuration");
    property p_post_clear;
        i_ce && $fell(busy_s) |=> o_global_reset && o_blk_set_reset;
    endproperty
    a_post_clear: assert property (p_post_clear)
        else $error("no clear right after configuration");
    property p_sr_idle;
        i_ce && !cfg_clear && !route_r[ROUTE_SR_USED] |=> !o_blk_set_reset;
    endproperty
    a_sr_idle: assert property (p_sr_idle)
        else $error("unused set/reset acted");
    property p_sr_even;
        i_ce && !cfg_clear && route_r[ROUTE_SR_USED] |=> o_blk_set_reset == $past(sr_src);
    endproperty
    a_sr_even: assert property (p_sr_even)
        else $error("set/reset not from chosen even buffer");
    property p_lock_time;
        $rose(o_loop_lock) |-> $past(lock_cnt) == 32'(LOCK_CYC - 1);
    endproperty
    a_lock_time: assert property (p_lock_time)
        else $error("lock rose before the lock time");
    property p_loss;
        i_ce && o_loop_lock && !act |=> !o_loop_lock;
    endproperty
    a_loss: assert property (p_loss)
        else $error("lock kept after loss of reference");
    property p_relock;
        s_relock |=> !o_loop_lock;
    endproperty
    a_relock: assert property (p_relock)
        else $error("lock kept across dynamic phase change");
    property p_load;
        s_release |=> loop_r == $past(shreg) && !o_loop_lock;
    endproperty
    a_load: assert property (p_load)
        else $error("shifted settings not loaded on reset release");
    property p_rst_lock;
        i_ce && !loop_rst_n |=> !o_loop_lock [*2];
    endproperty
    a_rst_lock: assert property (p_rst_lock)
        else $error("lock high while loop reset held");
    property p_bypass;
        i_ce && !loop_r[LOOP_HOLD] && loop_r[LOOP_BYPASS]
            |=> o_loop_out_to_global == $past(ref_now);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass did not pass the reference");
    property p_divide;
        i_ce && !loop_r[LOOP_HOLD] && !loop_r[LOOP_BYPASS]
            |=> o_loop_out_to_global == $past(syn_clk);
    endproperty
    a_divide: assert property (p_divide)
        else $error("output not from the divided clock");
    property p_hold;
        i_ce && loop_r[LOOP_HOLD] |=> $stable(o_loop_out_to_global);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output moved in low-power hold");
    property p_delay;
        i_ce && !dyn |=> o_fine_delay == 8'h00;
    endproperty
    a_delay: assert property (p_delay)
        else $error("fine delay applied in static mode");
endmodule

// >>> verif/gcn_fabric_model.sv
// gcn_fabric_model: fabric logic that reprograms the loop over its serial port
// assumes tasks are called from a process running on i_clk
`timescale 1ns/1ps
module gcn_fabric_model (
    input wire logic i_clk,
    output logic o_sclk,
    output logic o_sdata,
    output logic o_reset_n
);
    // serial clock stands low outside frames; loop reset released
    initial begin
        {o_sclk, o_sdata, o_reset_n} = 3'h1;
    end
    // msb first, one bit per rising serial clock edge
    task automatic shift_word(input logic [15:0] w, input int gap);
        for (int b = 15; b >= 0; b--) begin
            @(posedge i_clk) o_sdata <= w[b];
            repeat (gap) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (gap) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        // idle data line shows the inverse, so a stale bit is never read as valid
        @(posedge i_clk) o_sdata <= ~w[0];
    endtask
    task automatic set_reset(input logic on);
        @(posedge i_clk) o_reset_n <= ~on;
    endtask
endmodule

// >>> verif/gcn_clock_ctrl_tb.sv
// gcn_clock_ctrl_tb: self-checking bench for the global clock and loop block
// assumes gcn_fabric_model drives the serial port; apb, pins and reference come from here
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module gcn_clock_ctrl_tb;
    import gcn_pkg::*;
    localparam int LF_H = 4;
    logic i_clk, rst, psel, pen, pwr, busy, rf, fb, sclk, loop_serial_data_in, rst_n, rdy, err, trz, grst;
    logic bclk, bsr, bce, bsa, og, of, lock;
    logic ce, rp, fp, pact;
    logic [3:0] lut;
    logic [7:0] padr, pins, fd, global_buffer, gpio, ofd;
    logic [15:0] w;
    logic [31:0] wdat, rdat, act, expv;
    logic [31:0] exp_q[$], rd_q[$];
    int sel_q[$];
    int mismatches = 0;
    int n_tests = 0;
    int t4, t5, tl, dv;
    gcn_clock_ctrl #(.LOCK_CYC(20), .REF_TIMEOUT(64), .LF_HALF(LF_H), .HF_HALF(1)) dut (
        .i_clk(i_clk), .i_sys_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy),
        .o_pslverr(err), .i_global_pin(pins), .i_config_busy(busy), .i_loop_ref_pin(rp),
        .i_loop_ref_fabric(rf), .i_loop_feedback_pin(fp), .i_loop_feedback_in(fb),
        .i_loop_sclk(sclk), .i_loop_serial_data_in(loop_serial_data_in), .i_loop_reset_n(rst_n),
        .i_fine_delay_ctrl(fd), .o_global_buffer(global_buffer), .o_pin_gpio(gpio),
        .o_global_tristate_ctrl(trz), .o_global_reset(grst), .o_blk_clk(bclk),
        .o_blk_lut_in(lut), .o_blk_set_reset(bsr), .o_blk_clk_en(bce), .o_blk_sr_async(bsa),
        .o_loop_out_to_global(og), .o_loop_out_to_fabric(of), .o_loop_lock(lock),
        .o_fine_delay(ofd));
    gcn_fabric_model fab (.i_clk(i_clk), .o_sclk(sclk), .o_sdata(loop_serial_data_in), .o_reset_n(rst_n));
    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // fabric reference and feedback always toggle; the pin pair only while pact is high
    always @(posedge i_clk) begin
        {rf, fb} <= ~{rf, fb};
        if (pact) begin
            {rp, fp} <= ~{rp, fp};
        end
    end
    // output groups that a note can ask for
    function automatic logic [31:0] pv(input int s);
        case (s)
            0: return {30'h0, trz, grst};
            1: return {16'h0, global_buffer & PIN_MASK, gpio};
            2: return {24'h0, bclk, lut, bsr, bce, bsa};
            3: return {24'h0, ofd};
            4: return {31'h0, lock};
            5: return {31'h0, err};
            6: return {30'h0, og ^ of, og ^ rf};
            default: return {8'(t4), 8'(t5), 16'(tl)};
        endcase
    endfunction
    // notes are looked at on the falling edge, once the rising edge has settled
    always @(negedge i_clk) begin
        while (sel_q.size() > 0) begin
            act = pv(sel_q.pop_front());
            expv = exp_q.pop_front();
            `CHK(act, expv)
        end
    end
    // read data is taken at the edge that completes the access
    always @(posedge i_clk) begin
        if (psel && pen && rdy && !pwr) begin
            `CHK(rdat, rd_q[0])
            void'(rd_q.pop_front());
        end
    end
    task automatic print_verdict;
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic fail_out;
        mismatches++;
        print_verdict;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic note(input int s, input logic [31:0] e);
        sel_q.push_back(s);
        exp_q.push_back(e);
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge i_clk);
        {psel, pwr, padr, wdat} <= {1'b1, wr, a, d};
        @(posedge i_clk);
        pen <= 1'b1;
        do @(posedge i_clk); while (rdy !== 1'b1 && ++i < 50);
        {psel, pen} <= 2'b00;
        if (rdy !== 1'b1) fail_out;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_lock;
        int i = 0;
        do @(posedge i_clk); while (lock !== 1'b1 && ++i < 300);
        if (lock !== 1'b1) fail_out;
    endtask
    // toggles of slow osc, fast osc and loop clock over n cycles
    task automatic count(input int n);
        logic [2:0] p;
        {t4, t5, tl} = 96'h0;
        @(negedge i_clk) p = {global_buffer[5:4], of};
        repeat (n) begin
            @(negedge i_clk);
            t4 += int'(global_buffer[4] !== p[1]);
            t5 += int'(global_buffer[5] !== p[2]);
            tl += int'(of !== p[0]);
            p = {global_buffer[5:4], of};
        end
    endtask
    // main sequence
    initial begin
        {rst, busy, psel, pen, pwr, rf, fb, padr, wdat} = {7'h60, 8'h00, 32'h0};
        {ce, rp, fp, pact} = 4'h8;
        pins = 8'($urandom(32'hfd550c96));
        fd = 8'($urandom());
        wt(5);
        rst <= 1'b0;
        wt(4);
        note(0, 32'h3);
        busy <= 1'b0;
        wt(10);
        note(0, 32'h0);
        note(1, {16'h0, pins & PIN_MASK, pins & PIN_MASK});
        apb(1'b1, ADDR_ROUTE, 32'h0019fc43);
        wt(4);
        note(2, {24'h0, pins[3], pins[7:6], pins[1:0], pins[6], pins[1], 1'b1});
        rd(ADDR_ROUTE, 32'h0019fc43);
        apb(1'b1, ADDR_ROUTE, 32'hffe00003);
        wt(4);
        note(2, {24'h0, pins[3], {4{pins[0]}}, 1'b0, pins[1], 1'b0});
        rd(ADDR_ROUTE, 32'h3);
        apb(1'b1, ADDR_LOOP, 32'he0);
        wt(4);
        note(3, {24'h0, fd});
        wait_lock;
        note(4, 32'h1);
        apb(1'b1, ADDR_LOOP, 32'h10e0);
        wt(2);
        note(4, 32'h0);
        wait_lock;
        apb(1'b1, ADDR_LOOP, 32'hc0);
        wt(4);
        note(3, 32'h0);
        // prompt then slow serial partner
        for (int g = 3; g <= 6; g += 3) begin
            // the slow pass asks for a divider above 64, which must clamp
            w = (g == 6) ? 16'h00c7 : (16'h00c0 | 16'($urandom_range(6)));
            dv = (w[2:0] > 3'h6) ? 6 : int'(w[2:0]);
            fab.shift_word(w, g);
            fab.set_reset(1'b1);
            wt(8);
            note(4, 32'h0);
            fab.set_reset(1'b0);
            wt(8);
            rd(ADDR_LOOP, {16'h0, w});
            wait_lock;
            count(128);
            note(7, {8'(128 / LF_H), 8'h80, 16'(128 >> dv)});
        end
        apb(1'b1, ADDR_LOOP, 32'hc8);
        wt(4);
        note(6, 32'h1);
        // low-power hold: the loop output stays put while the oscillators run on
        apb(1'b1, ADDR_LOOP, 32'hd0);
        wt(2);
        count(16);
        note(7, {8'(16 / LF_H), 8'h10, 16'h0});
        // pin reference and feedback: static pins lose lock, toggling pins regain it
        apb(1'b1, ADDR_LOOP, 32'h100);
        wt(100);
        note(4, 32'h0);
        pact <= 1'b1;
        wait_lock;
        note(4, 32'h1);
        // a frozen block keeps its lock although the pins stop, and loses it once running
        {ce, pact} <= 2'b00;
        wt(100);
        note(4, 32'h1);
        ce <= 1'b1;
        wt(100);
        note(4, 32'h0);
        rd(8'h0c, 32'h0);
        note(5, 32'h1);
        wt(2);
        print_verdict;
    end
endmodule
